// *** rtl/adcstw_cfg.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the converter control block
// Assumes: 125 MHz core clock, APB byte addresses inside one register page
// Notes:   timing counts derive from the times in ns and the clock rate
`ifndef ADCSTW_CFG_SVH
`define ADCSTW_CFG_SVH

// page decode: paddr[13:8] selects the page, paddr[7:0] the register
`define ADCSTW_PAGE           6'h3F
`define ADCSTW_OFF_CTRL       8'h00
`define ADCSTW_OFF_IRQ        8'h04
`define ADCSTW_OFF_MASK       8'h08
`define ADCSTW_OFF_VEC        8'h0C
`define ADCSTW_OFF_CMP        8'h10
`define ADCSTW_OFF_UP6        8'h14
`define ADCSTW_OFF_LO6        8'h18
`define ADCSTW_OFF_UP7        8'h1C
`define ADCSTW_OFF_LO7        8'h20
`define ADCSTW_OFF_RES0       8'h40
`define ADCSTW_OFF_RES7       8'h5C

// converter_control_reg fields
`define ADCSTW_CTRL_GO        0
`define ADCSTW_CTRL_REPEAT    1
`define ADCSTW_CTRL_ENERGIZE  2
`define ADCSTW_CTRL_ONCHIP    3
`define ADCSTW_CTRL_PIN       4
`define ADCSTW_CTRL_FIRST_LSB 5
`define ADCSTW_CTRL_FIRST_MSB 7

// converter_irq_control_reg and mask fields
`define ADCSTW_IRQ_DONE       7
`define ADCSTW_IRQ_ALARM      6

// threshold_result_reg fields
`define ADCSTW_CMP_LO6        0
`define ADCSTW_CMP_HI6        1
`define ADCSTW_CMP_LO7        2
`define ADCSTW_CMP_HI7        3

// reset values
`define ADCSTW_RST_BYTE       8'h00
`define ADCSTW_RST_UPPER      8'hFF
`define ADCSTW_RST_LOWER      8'h00
`define ADCSTW_LAST_CHAN      3'h7
`define ADCSTW_WD_CHAN6       3'h6
`define ADCSTW_WD_CHAN7       3'h7

// timing
`define ADCSTW_CLK_MHZ        125
`define ADCSTW_CONV_TIME_NS   11000
`define ADCSTW_SAMPLE_TIME_NS 3000
`define ADCSTW_TRIG_MIN_NS    80
`define ADCSTW_SAR_BITS       8
`define ADCSTW_CONV_CYC       ((`ADCSTW_CONV_TIME_NS * `ADCSTW_CLK_MHZ) / 1000)
`define ADCSTW_SAMPLE_CYC     ((`ADCSTW_SAMPLE_TIME_NS * `ADCSTW_CLK_MHZ) / 1000)
`define ADCSTW_BIT_CYC        ((`ADCSTW_CONV_CYC - `ADCSTW_SAMPLE_CYC) / `ADCSTW_SAR_BITS)

`endif

// *** rtl/adcstw_pkg.sv ***
// Purpose: shared types of the converter control block
// Assumes: nothing beyond the cfg header
// Notes:   constants live in adcstw_cfg.svh
package adcstw_pkg;

    typedef logic [7:0] adcstw_byte_t;
    typedef logic [2:0] adcstw_chan_t;

    typedef enum logic [1:0]
    {
        ADCSTW_IDLE   = 2'b00,
        ADCSTW_SAMPLE = 2'b01,
        ADCSTW_APPROX = 2'b10
    } adcstw_phase_t;

endpackage

// *** rtl/adcstw_sar.sv ***
// Purpose: successive approximation sequencer for one channel conversion
// Assumes: analog comparator high when input is above dac_code
// Notes:   sample phase then one bit per divider tick, msb first
`timescale 1ns/1ps
`include "adcstw_cfg.svh"

module adcstw_sar (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 start,
    input  wire logic                 abort,
    input  wire logic                 cmp_pin,
    output logic                      sample_hold,
    output adcstw_pkg::adcstw_byte_t  dac_code,
    output adcstw_pkg::adcstw_byte_t  result,
    output logic                      done,
    output logic                      busy
);
    import adcstw_pkg::*;

    localparam logic [10:0] SAMPLE_LAST = 11'(`ADCSTW_SAMPLE_CYC - 1);
    localparam logic [10:0] BIT_LAST    = 11'(`ADCSTW_BIT_CYC - 1);

    adcstw_phase_t phase_q;
    logic [10:0]   cnt_q;
    logic [2:0]    bit_q;
    adcstw_byte_t  trial_q;
    logic          cmp_meta_q;
    logic          cmp_q;
    logic          tick;

    // comparator output is asynchronous to the core clock
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cmp_meta_q <= 1'b0;
            cmp_q      <= 1'b0;
        end
        else
        begin
            cmp_meta_q <= cmp_pin;
            cmp_q      <= cmp_meta_q;
        end
    end

    // divider enable: end of sample window or of one bit trial
    assign tick = (cnt_q == 11'h000);

    always_ff @(posedge clock)
    begin
        if (!rst_n || abort)
        begin
            phase_q <= ADCSTW_IDLE;
            cnt_q   <= 11'h000;
            bit_q   <= 3'h7;
            trial_q <= 8'h00;
        end
        else
        begin
            case (phase_q)
                ADCSTW_IDLE:
                begin
                    if (start)
                    begin
                        phase_q <= ADCSTW_SAMPLE;
                        cnt_q   <= SAMPLE_LAST;
                        trial_q <= 8'h00;
                    end
                end
                ADCSTW_SAMPLE:
                begin
                    if (tick)
                    begin
                        phase_q <= ADCSTW_APPROX;
                        cnt_q   <= BIT_LAST;
                        bit_q   <= 3'h7;
                        trial_q <= 8'h80;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 11'h001;
                    end
                end
                ADCSTW_APPROX:
                begin
                    if (tick)
                    begin
                        cnt_q <= BIT_LAST;
                        if (!cmp_q)
                        begin
                            trial_q[bit_q] <= 1'b0;
                        end
                        if (bit_q == 3'h0)
                        begin
                            phase_q <= ADCSTW_IDLE;
                        end
                        else
                        begin
                            trial_q[bit_q - 3'h1] <= 1'b1;
                            bit_q                 <= bit_q - 3'h1;
                        end
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 11'h001;
                    end
                end
                default:
                begin
                    phase_q <= ADCSTW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            done   <= 1'b0;
            result <= 8'h00;
        end
        else
        begin
            done <= 1'b0;
            if (!abort && phase_q == ADCSTW_APPROX && tick && bit_q == 3'h0)
            begin
                done      <= 1'b1;
                result    <= {trial_q[7:1], cmp_q};
            end
        end
    end

    assign sample_hold = (phase_q == ADCSTW_SAMPLE);
    assign dac_code    = trial_q;
    assign busy        = (phase_q != ADCSTW_IDLE);

endmodule

// *** rtl/adcstw_top.sv ***
// Purpose: scan, trigger, result, threshold and interrupt control of an 8-channel SAR converter
// Assumes: APB slave, zero wait states; timer_event is on the core clock
// Notes:   one conversion takes 1375 core cycles including a 375-cycle sample window
`timescale 1ns/1ps
`include "adcstw_cfg.svh"

module adcstw_top (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [15:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 trigger_input_pin,
    input  wire logic                 timer_event,
    input  wire logic                 analog_compare_pin,
    output logic                      analog_power_on,
    output adcstw_pkg::adcstw_chan_t  channel_select,
    output logic                      sample_hold,
    output adcstw_pkg::adcstw_byte_t  dac_code,
    output logic                      irq,
    output adcstw_pkg::adcstw_byte_t  irq_vector
);
    import adcstw_pkg::*;

    // register page decode, shared by write and read paths
    function automatic logic reg_hit(input logic [15:0] a, input logic [7:0] off);
        reg_hit = (a[15:14] == 2'b00) && (a[13:8] == `ADCSTW_PAGE) && (a[7:0] == off);
    endfunction

    function automatic logic res_hit(input logic [15:0] a);
        res_hit = (a[15:14] == 2'b00) && (a[13:8] == `ADCSTW_PAGE) && (a[1:0] == 2'b00)
                  && (a[7:0] >= `ADCSTW_OFF_RES0) && (a[7:0] <= `ADCSTW_OFF_RES7);
    endfunction

    adcstw_byte_t ctrl_q;
    adcstw_byte_t mask_q;
    adcstw_byte_t vec_q;
    adcstw_byte_t up6_q;
    adcstw_byte_t lo6_q;
    adcstw_byte_t up7_q;
    adcstw_byte_t lo7_q;
    adcstw_byte_t result_q [8];
    logic         go_q;
    logic         done_flag_q;
    logic         alarm_flag_q;
    logic [3:0]   cmp_flags_q;
    logic         scan_q;
    adcstw_chan_t chan_q;
    logic         sar_start_q;
    logic         trig_meta_q;
    logic         trig_sync_q;
    logic         trig_prev_q;
    logic [31:0]  prdata_q;

    logic         wr_en;
    logic         rd_setup;
    logic         mapped;
    logic         energize;
    logic         trig_event;
    logic         sar_done;
    adcstw_byte_t sar_result;
    logic         group_end;
    logic [3:0]   cmp_set;
    logic         alarm_set;
    logic         lo_hit;
    logic         hi_hit;
    adcstw_byte_t irq_status;
    adcstw_byte_t rd_byte;

    assign mapped = reg_hit(paddr, `ADCSTW_OFF_CTRL) || reg_hit(paddr, `ADCSTW_OFF_IRQ)
                    || reg_hit(paddr, `ADCSTW_OFF_MASK) || reg_hit(paddr, `ADCSTW_OFF_VEC)
                    || reg_hit(paddr, `ADCSTW_OFF_CMP) || reg_hit(paddr, `ADCSTW_OFF_UP6)
                    || reg_hit(paddr, `ADCSTW_OFF_LO6) || reg_hit(paddr, `ADCSTW_OFF_UP7)
                    || reg_hit(paddr, `ADCSTW_OFF_LO7) || res_hit(paddr);

    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign wr_en    = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata   = prdata_q;

    assign energize = ctrl_q[`ADCSTW_CTRL_ENERGIZE];
    assign analog_power_on = energize;

    // trigger pin is asynchronous: two flops, then edge detect
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            trig_meta_q <= 1'b0;
            trig_sync_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end
        else
        begin
            trig_meta_q <= trigger_input_pin;
            trig_sync_q <= trig_meta_q;
            trig_prev_q <= trig_sync_q;
        end
    end

    // pulses of 80 ns span ten clocks, so the synchroniser cannot miss one
    assign trig_event = (ctrl_q[`ADCSTW_CTRL_PIN] && trig_sync_q && !trig_prev_q)
                        || (ctrl_q[`ADCSTW_CTRL_ONCHIP] && timer_event);

    // control register, go bit kept apart for hardware set and clear
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrl_q <= `ADCSTW_RST_BYTE;
        end
        else if (wr_en && reg_hit(paddr, `ADCSTW_OFF_CTRL))
        begin
            ctrl_q <= pwdata[7:0];
        end
    end

    assign group_end = sar_done && (chan_q == `ADCSTW_LAST_CHAN);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            go_q <= 1'b0;
        end
        else if (wr_en && reg_hit(paddr, `ADCSTW_OFF_CTRL) && !pwdata[`ADCSTW_CTRL_ENERGIZE])
        begin
            go_q <= 1'b0;
        end
        else if (trig_event && energize)
        begin
            go_q <= 1'b1;
        end
        else if (wr_en && reg_hit(paddr, `ADCSTW_OFF_CTRL))
        begin
            go_q <= pwdata[`ADCSTW_CTRL_GO];
        end
        else if (group_end && !ctrl_q[`ADCSTW_CTRL_REPEAT])
        begin
            go_q <= 1'b0;
        end
    end

    // channel sequencing across a group
    always_ff @(posedge clock)
    begin
        if (!rst_n || !energize)
        begin
            scan_q      <= 1'b0;
            chan_q      <= 3'h0;
            sar_start_q <= 1'b0;
        end
        else
        begin
            sar_start_q <= 1'b0;
            if (!scan_q)
            begin
                if (go_q)
                begin
                    scan_q      <= 1'b1;
                    chan_q      <= ctrl_q[`ADCSTW_CTRL_FIRST_MSB:`ADCSTW_CTRL_FIRST_LSB];
                    sar_start_q <= 1'b1;
                end
            end
            else if (sar_done)
            begin
                if (!go_q)
                begin
                    scan_q <= 1'b0;
                end
                else if (chan_q != `ADCSTW_LAST_CHAN)
                begin
                    chan_q      <= chan_q + 3'h1;
                    sar_start_q <= 1'b1;
                end
                else if (ctrl_q[`ADCSTW_CTRL_REPEAT])
                begin
                    chan_q      <= ctrl_q[`ADCSTW_CTRL_FIRST_MSB:`ADCSTW_CTRL_FIRST_LSB];
                    sar_start_q <= 1'b1;
                end
                else
                begin
                    scan_q <= 1'b0;
                end
            end
        end
    end

    adcstw_sar u_sar (
        .clock       (clock),
        .rst_n       (rst_n),
        .start       (sar_start_q),
        .abort       (!energize),
        .cmp_pin     (analog_compare_pin),
        .sample_hold (sample_hold),
        .dac_code    (dac_code),
        .result      (sar_result),
        .done        (sar_done),
        .busy        ()
    );

    assign channel_select = chan_q;

    // per-channel result storage
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_res
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                begin
                    result_q[i] <= `ADCSTW_RST_BYTE;
                end
                else if (sar_done && chan_q == 3'(i))
                begin
                    result_q[i] <= sar_result;
                end
            end
        end
    endgenerate

    // limit registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            up6_q <= `ADCSTW_RST_UPPER;
            lo6_q <= `ADCSTW_RST_LOWER;
            up7_q <= `ADCSTW_RST_UPPER;
            lo7_q <= `ADCSTW_RST_LOWER;
        end
        else if (wr_en)
        begin
            if (reg_hit(paddr, `ADCSTW_OFF_UP6))
            begin
                up6_q <= pwdata[7:0];
            end
            if (reg_hit(paddr, `ADCSTW_OFF_LO6))
            begin
                lo6_q <= pwdata[7:0];
            end
            if (reg_hit(paddr, `ADCSTW_OFF_UP7))
            begin
                up7_q <= pwdata[7:0];
            end
            if (reg_hit(paddr, `ADCSTW_OFF_LO7))
            begin
                lo7_q <= pwdata[7:0];
            end
        end
    end

    // threshold check on the fresh result of channel 6 or 7
    always_comb
    begin
        lo_hit  = 1'b0;
        hi_hit  = 1'b0;
        cmp_set = 4'h0;
        if (chan_q == `ADCSTW_WD_CHAN6)
        begin
            lo_hit = sar_result < lo6_q;
            hi_hit = sar_result > up6_q;
        end
        else if (chan_q == `ADCSTW_WD_CHAN7)
        begin
            lo_hit = sar_result < lo7_q;
            hi_hit = sar_result > up7_q;
        end
        if (sar_done)
        begin
            cmp_set[`ADCSTW_CMP_LO6] = lo_hit && (chan_q == `ADCSTW_WD_CHAN6);
            cmp_set[`ADCSTW_CMP_HI6] = hi_hit && (chan_q == `ADCSTW_WD_CHAN6);
            cmp_set[`ADCSTW_CMP_LO7] = lo_hit && (chan_q == `ADCSTW_WD_CHAN7);
            cmp_set[`ADCSTW_CMP_HI7] = hi_hit && (chan_q == `ADCSTW_WD_CHAN7);
        end
    end

    assign alarm_set = |cmp_set;

    // sticky status, write one to clear, hardware set wins
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cmp_flags_q  <= 4'h0;
            done_flag_q  <= 1'b0;
            alarm_flag_q <= 1'b0;
        end
        else
        begin
            if (wr_en && reg_hit(paddr, `ADCSTW_OFF_CMP))
            begin
                cmp_flags_q <= (cmp_flags_q & ~pwdata[3:0]) | cmp_set;
            end
            else
            begin
                cmp_flags_q <= cmp_flags_q | cmp_set;
            end
            if (wr_en && reg_hit(paddr, `ADCSTW_OFF_IRQ))
            begin
                done_flag_q  <= (done_flag_q && !pwdata[`ADCSTW_IRQ_DONE]) || group_end;
                alarm_flag_q <= (alarm_flag_q && !pwdata[`ADCSTW_IRQ_ALARM]) || alarm_set;
            end
            else
            begin
                done_flag_q  <= done_flag_q || group_end;
                alarm_flag_q <= alarm_flag_q || alarm_set;
            end
        end
    end

    // mask and vector base
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mask_q <= `ADCSTW_RST_BYTE;
            vec_q  <= `ADCSTW_RST_BYTE;
        end
        else if (wr_en)
        begin
            if (reg_hit(paddr, `ADCSTW_OFF_MASK))
            begin
                mask_q <= pwdata[7:0] & 8'hC0;
            end
            if (reg_hit(paddr, `ADCSTW_OFF_VEC))
            begin
                vec_q <= pwdata[7:0] & 8'hFC;
            end
        end
    end

    always_comb
    begin
        irq_status                   = 8'h00;
        irq_status[`ADCSTW_IRQ_DONE]  = done_flag_q;
        irq_status[`ADCSTW_IRQ_ALARM] = alarm_flag_q;
    end

    assign irq = |(irq_status & mask_q);

    // alarm has priority; the hardware bit picks the slot in the four-byte area
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            irq_vector <= `ADCSTW_RST_BYTE;
        end
        else
        begin
            irq_vector <= {vec_q[7:2], !(alarm_flag_q && mask_q[`ADCSTW_IRQ_ALARM]), 1'b0};
        end
    end

    // read data captured in the setup phase
    always_comb
    begin
        rd_byte = 8'h00;
        if (reg_hit(paddr, `ADCSTW_OFF_CTRL))
        begin
            rd_byte = {ctrl_q[7:1], go_q};
        end
        else if (reg_hit(paddr, `ADCSTW_OFF_IRQ))
        begin
            rd_byte = irq_status;
        end
        else if (reg_hit(paddr, `ADCSTW_OFF_MASK))
        begin
            rd_byte = mask_q;
        end
        else if (reg_hit(paddr, `ADCSTW_OFF_VEC))
        begin
            rd_byte = {vec_q[7:2], !(alarm_flag_q && mask_q[`ADCSTW_IRQ_ALARM]), 1'b0};
        end
        else if (reg_hit(paddr, `ADCSTW_OFF_CMP))
        begin
            rd_byte = {4'h0, cmp_flags_q};
        end
        else if (reg_hit(paddr, `ADCSTW_OFF_UP6))
        begin
            rd_byte = up6_q;
        end
        else if (reg_hit(paddr, `ADCSTW_OFF_LO6))
        begin
            rd_byte = lo6_q;
        end
        else if (reg_hit(paddr, `ADCSTW_OFF_UP7))
        begin
            rd_byte = up7_q;
        end
        else if (reg_hit(paddr, `ADCSTW_OFF_LO7))
        begin
            rd_byte = lo7_q;
        end
        else if (res_hit(paddr))
        begin
            rd_byte = result_q[paddr[4:2]];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (rd_setup)
        begin
            prdata_q <= {24'h00_0000, rd_byte};
        end
    end

endmodule

// *** bench/adcstw_asserts.sv ***
// Purpose: port checks of the converter control block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into adcstw_top
`timescale 1ns/1ps
`include "adcstw_cfg.svh"

module adcstw_asserts import adcstw_pkg::*;
(
    input wire logic               clock,
    input wire logic               rst_n,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [15:0]        paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               analog_power_on,
    input wire logic               sample_hold,
    input wire adcstw_pkg::adcstw_byte_t dac_code
);
    logic [9:0] sh_cnt_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n || !sample_hold)
            sh_cnt_q <= 10'h000;
        else
            sh_cnt_q <= sh_cnt_q + 10'h001;
    end

    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_rd;
        s_acc ##0 !pwrite;
    endsequence

    property p_pready;
        psel |-> pready;
    endproperty
    property p_err_acc;
        pslverr |-> psel && penable;
    endproperty
    property p_page;
        s_acc ##0 (paddr[13:8] != `ADCSTW_PAGE) |-> pslverr;
    endproperty
    property p_rd_err;
        s_rd ##0 pslverr |-> prdata == 32'h0;
    endproperty
    property p_hi;
        s_rd |-> prdata[31:8] == 24'h0;
    endproperty
    property p_pwr;
        !analog_power_on ##1 !analog_power_on |-> !sample_hold;
    endproperty
    property p_sample;
        $fell(sample_hold) |-> sh_cnt_q == 10'h177 || !analog_power_on;
    endproperty
    property p_dac;
        $fell(sample_hold) && analog_power_on |-> ##[0:2] dac_code == 8'h80;
    endproperty

    a_pready:  assert property (p_pready)  else $error("pready low");
    a_err_acc: assert property (p_err_acc) else $error("stray error");
    a_page:    assert property (p_page)    else $error("page decode");
    a_rd_err:  assert property (p_rd_err)  else $error("error data");
    a_hi:      assert property (p_hi)      else $error("upper bits");
    a_pwr:     assert property (p_pwr)     else $error("sampling off");
    a_sample:  assert property (p_sample)  else $error("sample length");
    a_dac:     assert property (p_dac)     else $error("first trial");
endmodule

bind adcstw_top adcstw_asserts i_adcstw_asserts (.clock, .rst_n, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .analog_power_on, .sample_hold, .dac_code);

// *** bench/adcstw_sensor.sv ***
// Purpose: analog input and comparator seen by the converter
// Assumes: level sits half a step above its code
// Notes:   a full conversion returns level exactly
`timescale 1ns/1ps

module adcstw_sensor import adcstw_pkg::*;
(
    input wire adcstw_pkg::adcstw_byte_t level,
    input wire adcstw_pkg::adcstw_byte_t dac_code,
    output logic                         analog_compare_pin
);
    assign analog_compare_pin = (level >= dac_code);
endmodule

// *** bench/testbench.sv ***
// Purpose: self-checking bench of the converter control block
// Assumes: 125 MHz clock, zero-wait APB slave
// Notes:   conversions run at full length
`timescale 1ns/1ps
`include "adcstw_cfg.svh"

module testbench;
    import adcstw_pkg::*;
    logic         clock = 1'b0;
    logic         rst_n = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [15:0]  paddr = 16'h0;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         trigger_input_pin = 1'b0;
    logic         timer_event = 1'b0;
    logic         analog_compare_pin;
    logic         analog_power_on;
    logic         sample_hold;
    adcstw_byte_t dac_code;
    logic         irq;
    adcstw_chan_t chsel;
    adcstw_byte_t ivec;
    adcstw_byte_t level = 8'h20;
    logic [31:0]  rdat;
    logic         rerr;
    int           mismatches = 0;
    int           n_checks = 0;

    always #4 clock = ~clock;

    adcstw_top i_adcstw_top (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .trigger_input_pin, .timer_event, .analog_compare_pin,
        .analog_power_on, .channel_select(chsel), .sample_hold, .dac_code, .irq, .irq_vector(ivec));
    adcstw_sensor i_adcstw_sensor (.level, .dac_code, .analog_compare_pin);

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        xfer(1'b1, {2'h0, `ADCSTW_PAGE, off}, d);
    endtask

    task automatic chk(input logic [7:0] off, input logic [7:0] exp);
        xfer(1'b0, {2'h0, `ADCSTW_PAGE, off}, 8'h00);
        cmp(rdat, {24'h0, exp});
    endtask

    task automatic wait_irq;
        int i;
        for (i = 0; i < 3000 && irq !== 1'b1; i++)
            @(posedge clock);
        cmp(irq, 1'b1);
    endtask

    task automatic clr;
        wr(`ADCSTW_OFF_CMP, 8'h0F);
        wr(`ADCSTW_OFF_IRQ, 8'hC0);
    endtask

    task automatic t_reset;
        chk(`ADCSTW_OFF_CTRL, 8'h00);
        chk(`ADCSTW_OFF_UP6, 8'hFF);
        xfer(1'b1, 16'h0000, 8'h5A);
        cmp(rerr, 1'b1);
        xfer(1'b0, {2'h0, `ADCSTW_PAGE, 8'h30}, 8'h00);
        cmp(rerr, 1'b1);
    endtask

    task automatic t_single;
        wr(`ADCSTW_OFF_LO6, 8'h30);
        wr(`ADCSTW_OFF_LO7, 8'h20);
        wr(`ADCSTW_OFF_MASK, 8'h80);
        wr(`ADCSTW_OFF_VEC, 8'hA0);
        wr(`ADCSTW_OFF_CTRL, 8'hC5);
        @(posedge clock);
        cmp(chsel, 3'h6);
        wait_irq();
        cmp(chsel, 3'h7);
        cmp(ivec, 8'hA2);
        chk(`ADCSTW_OFF_CTRL, 8'hC4);
        chk(8'h58, 8'h20);
        chk(`ADCSTW_OFF_CMP, 8'h01);
        chk(`ADCSTW_OFF_IRQ, 8'hC0);
        chk(`ADCSTW_OFF_VEC, 8'hA2);
        wr(`ADCSTW_OFF_MASK, 8'h40);
        chk(`ADCSTW_OFF_VEC, 8'hA0);
        cmp(ivec, 8'hA0);
        clr();
        chk(`ADCSTW_OFF_CMP, 8'h00);
        cmp(irq, 1'b0);
        wr(`ADCSTW_OFF_MASK, 8'h80);
    endtask

    task automatic t_pin;
        level = 8'h9C;
        wr(`ADCSTW_OFF_UP7, 8'h80);
        wr(`ADCSTW_OFF_CTRL, 8'hF4);
        trigger_input_pin <= 1'b1;
        repeat (12) @(posedge clock);
        trigger_input_pin <= 1'b0;
        wait_irq();
        chk(`ADCSTW_OFF_RES7, 8'h9C);
        chk(`ADCSTW_OFF_CMP, 8'h08);
        clr();
    endtask

    task automatic t_timer;
        level = 8'h10;
        wr(`ADCSTW_OFF_CTRL, 8'hEC);
        timer_event <= 1'b1;
        @(posedge clock);
        timer_event <= 1'b0;
        wait_irq();
        chk(`ADCSTW_OFF_RES7, 8'h10);
        clr();
    endtask

    task automatic t_auto;
        wr(`ADCSTW_OFF_CTRL, 8'hE7);
        wait_irq();
        clr();
        level = 8'h44;
        wait_irq();
        chk(`ADCSTW_OFF_RES7, 8'h44);
        chk(`ADCSTW_OFF_CTRL, 8'hE7);
        wr(`ADCSTW_OFF_CTRL, 8'h00);
        repeat (4) @(posedge clock);
        cmp(analog_power_on, 1'b0);
        cmp(sample_hold, 1'b0);
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge clock);
        mismatches++;
        wrap_up();
    end

    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_single();
        t_pin();
        t_timer();
        t_auto();
        wrap_up();
    end
endmodule
